// >>> rtl/tse_eeprom.sv
// three-wire serial word memory: instruction decoder, access sequencer,
// self-timed programming and ready/busy answer, 64 words of 16 bits
// assumes host pins are asynchronous to clk_sys and the serial clock is far slower
`timescale 1ns/1ps
`default_nettype none
module tse_eeprom
	import tse_pkg::*;
#(
	parameter int PROG_CYC = PROG_CYC_DEF
) (
	input wire logic clk_sys, // 20 MHz system clock
	input wire logic rst_b, // active-low asynchronous reset, power-up
	input wire logic chip_select_pin, // chip select from host, active high
	input wire logic serial_clock_pin, // serial clock from host
	input wire logic serial_in_pin, // serial data from host
	output logic serial_out_pin, // serial data or ready/busy to host
	output logic serial_out_oe // high while serial_out_pin is driven
);

	////////////////////////////////////////////////////////////////////////
	// reset release and pin synchronisation

	logic rst_meta;
	logic rst_n;

	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			rst_meta <= 1'b0;
			rst_n <= 1'b0;
		end else begin
			rst_meta <= 1'b1;
			rst_n <= rst_meta;
		end
	end

	tse_pins_s pins_raw;
	tse_pins_s pins;
	tse_pins_s pins_d;

	assign pins_raw.cs = chip_select_pin;
	assign pins_raw.sk = serial_clock_pin;
	assign pins_raw.di = serial_in_pin;

	tse_sync #(
		.W($bits(tse_pins_s))
	) u_sync (
		.clk(clk_sys),
		.rst_n(rst_n),
		.d(pins_raw),
		.q(pins)
	);

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			pins_d <= '0;
		end else begin
			pins_d <= pins;
		end
	end

	logic sk_rise;
	logic cs_rise;

	assign sk_rise = pins.cs & pins.sk & ~pins_d.sk;
	assign cs_rise = pins.cs & ~pins_d.cs;

	////////////////////////////////////////////////////////////////////////
	// chip select low time, for the status request

	logic [CSL_W-1:0] cs_low_cnt;
	logic cs_low_ok;

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			cs_low_cnt <= '0;
		end else if (pins.cs) begin
			cs_low_cnt <= '0;
		end else if (cs_low_cnt < CSL_W'(CS_LOW_MIN_CYC)) begin
			cs_low_cnt <= cs_low_cnt + 1'b1;
		end
	end

	assign cs_low_ok = (cs_low_cnt >= CSL_W'(CS_LOW_MIN_CYC));

	////////////////////////////////////////////////////////////////////////
	// instruction sequencer

	tse_state_e state;
	logic [CNT_W-1:0] bit_cnt;
	logic [CMD_BITS-1:0] cmd_sr;
	logic [CMD_BITS-1:0] next_cmd;
	logic [DATA_W-1:0] data_sr;
	logic [DATA_W-1:0] next_data;
	logic [DATA_W-1:0] out_sr;
	logic [OP_W-1:0] cur_op;
	logic [ADDR_W-1:0] cur_addr;
	logic prog_en;
	logic busy;
	logic cmd_done;
	logic data_done;
	logic rd_start;
	logic rd_shift;
	logic prog_go;
	logic prog_all;
	logic [DATA_W-1:0] prog_word;
	logic [ADDR_W-1:0] prog_addr_in;
	logic start_seen;

	assign next_cmd = {cmd_sr[CMD_BITS-2:0], pins.di};
	assign next_data = {data_sr[DATA_W-2:0], pins.di};
	assign cmd_done = (state == ST_CMD) && sk_rise && (bit_cnt == CMD_LAST);
	assign data_done = (state == ST_DATA) && sk_rise && (bit_cnt == DATA_LAST);
	// a new instruction is refused while a programming cycle runs
	assign start_seen = sk_rise && pins.di && !busy;
	assign rd_start = cmd_done && (next_cmd[CMD_BITS-1 -: OP_W] == OP_READ);
	assign rd_shift = (state == ST_READ) && sk_rise;

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			state <= ST_IDLE;
			bit_cnt <= '0;
			cmd_sr <= '0;
			data_sr <= '0;
			cur_op <= OP_EXT;
			cur_addr <= '0;
		end else if (!pins.cs) begin
			state <= ST_IDLE;
			bit_cnt <= '0;
		end else begin
			case (state)
				ST_IDLE: begin
					// only a fresh rise after a long enough low asks for status
					if (cs_rise && busy && cs_low_ok) begin
						state <= ST_STATUS;
					end else begin
						state <= ST_WAIT_START;
					end
				end
				ST_WAIT_START, ST_STATUS: begin
					if (start_seen) begin
						state <= ST_CMD;
						bit_cnt <= '0;
					end
				end
				ST_CMD: begin
					if (sk_rise) begin
						cmd_sr <= next_cmd;
						bit_cnt <= bit_cnt + 1'b1;
						if (bit_cnt == CMD_LAST) begin
							cur_op <= next_cmd[CMD_BITS-1 -: OP_W];
							cur_addr <= next_cmd[ADDR_W-1:0];
							bit_cnt <= '0;
							case (next_cmd[CMD_BITS-1 -: OP_W])
								OP_READ: state <= ST_READ;
								OP_WRITE: state <= ST_DATA;
								OP_ERASE: state <= ST_DONE;
								OP_EXT: begin
									if (next_cmd[ADDR_W-1 -: 2] == EXT_WRITE_ALL) begin
										state <= ST_DATA;
									end else begin
										state <= ST_DONE;
									end
								end
								default: state <= ST_DONE;
							endcase
						end
					end
				end
				ST_DATA: begin
					if (sk_rise) begin
						data_sr <= next_data;
						bit_cnt <= bit_cnt + 1'b1;
						if (bit_cnt == DATA_LAST) begin
							state <= ST_DONE;
						end
					end
				end
				ST_READ: begin
					if (sk_rise) begin
						bit_cnt <= bit_cnt + 1'b1;
						if (bit_cnt == DATA_LAST) begin
							state <= ST_DONE;
						end
					end
				end
				ST_DONE: begin
					state <= ST_DONE;
				end
				default: begin
					state <= ST_IDLE;
				end
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////
	// programming enable latch, cleared only by reset or disable

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			prog_en <= 1'b0;
		end else if (cmd_done && next_cmd[CMD_BITS-1 -: OP_W] == OP_EXT) begin
			if (next_cmd[ADDR_W-1 -: 2] == EXT_ENABLE) begin
				prog_en <= 1'b1;
			end else if (next_cmd[ADDR_W-1 -: 2] == EXT_DISABLE) begin
				prog_en <= 1'b0;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// programming request: erase kinds fire at decode, write kinds after data

	always_comb begin
		prog_go = 1'b0;
		prog_all = 1'b0;
		prog_word = ERASED_WORD;
		prog_addr_in = next_cmd[ADDR_W-1:0];
		if (cmd_done && prog_en) begin
			if (next_cmd[CMD_BITS-1 -: OP_W] == OP_ERASE) begin
				prog_go = 1'b1;
			end else if (next_cmd[CMD_BITS-1 -: OP_W] == OP_EXT &&
				next_cmd[ADDR_W-1 -: 2] == EXT_ERASE_ALL) begin
				prog_go = 1'b1;
				prog_all = 1'b1;
			end
		end else if (data_done && prog_en) begin
			prog_go = 1'b1;
			prog_word = next_data;
			prog_addr_in = cur_addr;
			prog_all = (cur_op == OP_EXT);
		end
	end

	////////////////////////////////////////////////////////////////////////
	// self-timed programming cycle

	logic [PROG_W-1:0] prog_cnt;
	logic pend_all;
	logic [ADDR_W-1:0] pend_addr;
	logic [DATA_W-1:0] pend_word;
	logic prog_end;

	assign prog_end = busy && (prog_cnt == PROG_W'(1));

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			busy <= 1'b0;
			prog_cnt <= '0;
			pend_all <= 1'b0;
			pend_addr <= '0;
			pend_word <= ZERO_WORD;
		end else if (prog_go && !busy) begin
			busy <= 1'b1;
			prog_cnt <= PROG_W'(PROG_CYC);
			pend_all <= prog_all;
			pend_addr <= prog_addr_in;
			pend_word <= prog_word;
		end else if (busy) begin
			prog_cnt <= prog_cnt - 1'b1;
			if (prog_end) begin
				busy <= 1'b0;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// array storage, committed at the end of the cycle

	logic [DATA_W-1:0] mem [WORDS];

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			for (int i = 0; i < WORDS; i++) begin
				mem[i] <= ERASED_WORD;
			end
		end else if (prog_end) begin
			for (int i = 0; i < WORDS; i++) begin
				if (pend_all || pend_addr == ADDR_W'(i)) begin
					mem[i] <= pend_word;
				end
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// read shifter

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			out_sr <= ZERO_WORD;
		end else if (rd_start) begin
			out_sr <= mem[next_cmd[ADDR_W-1:0]];
		end else if (rd_shift) begin
			out_sr <= {out_sr[DATA_W-2:0], 1'b0};
		end
	end

	////////////////////////////////////////////////////////////////////////
	// serial output pin; released whenever chip select is low

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			serial_out_pin <= 1'b0;
			serial_out_oe <= 1'b0;
		end else if (!pins.cs) begin
			serial_out_oe <= 1'b0;
		end else if (rd_start) begin
			serial_out_pin <= 1'b0;
			serial_out_oe <= 1'b1;
		end else if (rd_shift) begin
			serial_out_pin <= out_sr[DATA_W-1];
		end else if (state == ST_IDLE && cs_rise && busy && cs_low_ok) begin
			serial_out_pin <= 1'b0;
			serial_out_oe <= 1'b1;
		end else if (state == ST_STATUS) begin
			if (start_seen) begin
				serial_out_oe <= 1'b0;
			end else begin
				serial_out_pin <= ~busy;
			end
		end
	end

endmodule // tse_eeprom
`default_nettype wire

// >>> rtl/tse_pkg.sv
// constants, encodings and pin carrier for the three-wire serial word memory
// assumes a single 20 MHz system clock samples all three host pins
package tse_pkg;

	// array shape
	localparam int ADDR_W = 6;
	localparam int DATA_W = 16;
	localparam int OP_W = 2;
	localparam int WORDS = 64;
	localparam int CMD_BITS = OP_W + ADDR_W;
	localparam int CNT_W = 5;
	localparam logic [CNT_W-1:0] CMD_LAST = 5'h07;
	localparam logic [CNT_W-1:0] DATA_LAST = 5'h0f;

	// op codes following the start bit
	localparam logic [OP_W-1:0] OP_EXT = 2'h0;
	localparam logic [OP_W-1:0] OP_WRITE = 2'h1;
	localparam logic [OP_W-1:0] OP_READ = 2'h2;
	localparam logic [OP_W-1:0] OP_ERASE = 2'h3;

	// top two address bits select the extended command under OP_EXT
	localparam logic [1:0] EXT_DISABLE = 2'h0;
	localparam logic [1:0] EXT_WRITE_ALL = 2'h1;
	localparam logic [1:0] EXT_ERASE_ALL = 2'h2;
	localparam logic [1:0] EXT_ENABLE = 2'h3;

	localparam logic [DATA_W-1:0] ERASED_WORD = 16'hffff;
	localparam logic [DATA_W-1:0] ZERO_WORD = 16'h0000;

	// timing
	localparam int CLK_PERIOD_NS = 50;
	localparam int CLK_MHZ = 20;
	localparam int T_CS_LOW_NS = 250;
	localparam int CS_LOW_MIN_CYC = (T_CS_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int CSL_W = 3;
	localparam int T_WP_US = 3000;
	localparam int PROG_CYC_DEF = T_WP_US * CLK_MHZ;
	localparam int PROG_W = 24;

	// sequencer states, one-hot
	typedef enum logic [6:0] {
		ST_IDLE = 7'h01,
		ST_WAIT_START = 7'h02,
		ST_CMD = 7'h04,
		ST_DATA = 7'h08,
		ST_READ = 7'h10,
		ST_STATUS = 7'h20,
		ST_DONE = 7'h40
	} tse_state_e;

	// host pins travel together through the synchroniser
	typedef struct packed {
		logic cs;
		logic sk;
		logic di;
	} tse_pins_s;

endpackage

// >>> rtl/tse_sync.sv
// two-flop synchroniser for a group of asynchronous levels
// assumes an active-low reset already local to clk
`timescale 1ns/1ps
`default_nettype none
module tse_sync #(
	parameter int W = 1
) (
	input wire logic clk, // sampling clock
	input wire logic rst_n, // active-low reset
	input wire logic [W-1:0] d, // asynchronous levels
	output logic [W-1:0] q // synchronised levels
);
	logic [W-1:0] meta;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			meta <= '0;
			q <= '0;
		end else begin
			meta <= d;
			q <= meta;
		end
	end
endmodule // tse_sync
`default_nettype wire

// >>> test/tse_eeprom_asserts.sv
// pin-level assertions for the serial word memory
// bound to tse_eeprom from the bench top, sees only its ports
`timescale 1ns/1ps
`default_nettype none
module tse_eeprom_asserts (
	input wire logic clk_sys, // system clock
	input wire logic rst_b, // active-low reset
	input wire logic chip_select_pin, // host select
	input wire logic serial_clock_pin, // host serial clock
	input wire logic serial_in_pin, // host serial data
	input wire logic serial_out_pin, // device answer
	input wire logic serial_out_oe // device drive enable
);
	logic sk_q;
	logic [3:0] sk_age;
	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (!rst_b);
	////////////////////////////////////////////////////////////
	// clocks since the serial clock pin rose, saturating at 15
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			sk_q <= 1'b0;
			sk_age <= 4'hf;
		end else begin
			sk_q <= serial_clock_pin;
			if (serial_clock_pin && !sk_q) begin
				sk_age <= 4'h0;
			end else if (sk_age != 4'hf) begin
				sk_age <= sk_age + 4'h1;
			end
		end
	end
	////////////////////////////////////////////////////////////
	a_oe_needs_cs: assert property (
		$rose(serial_out_oe) |-> chip_select_pin
	) else $error("output enabled without select");
	a_quiet_reset: assert property (
		$rose(rst_b) |-> !serial_out_oe [*4]
	) else $error("output driven right after reset");
	a_first_bit_low: assert property (
		$rose(serial_out_oe) |-> !serial_out_pin
	) else $error("first answer bit not zero");
	// a still serial clock only allows the busy to ready step
	a_out_on_rise: assert property (
		serial_out_oe && $past(serial_out_oe) && $changed(serial_out_pin)
		|-> sk_age <= 4'h6 || (sk_age == 4'hf && serial_out_pin)
	) else $error("output changed away from a clock rise");
	a_ready_holds: assert property (
		serial_out_oe && serial_out_pin && chip_select_pin && sk_age == 4'hf
		|=> serial_out_pin || !serial_out_oe
	) else $error("ready fell back to busy");
	a_cs_fall_quiet: assert property (
		$fell(chip_select_pin) |-> ##[1:5] !serial_out_oe
	) else $error("output kept after deselect");
	a_cs_low_off: assert property (
		!chip_select_pin [*6] |-> !serial_out_oe
	) else $error("output driven while deselected");
	a_drop_cause: assert property (
		$fell(serial_out_oe) |-> !$past(chip_select_pin, 2) || sk_age < 4'h6
	) else $error("output released without cause");
endmodule // tse_eeprom_asserts
`default_nettype wire

// >>> test/tse_host.sv
// host model driving select, serial clock and serial data
// pins change on the falling system clock; serial clock still outside frames
`timescale 1ns/1ps
`default_nettype none
module tse_host (
	input wire logic clk_sys, // bench clock
	input wire logic serial_out_pin, // device answer
	output var logic chip_select_pin, // select
	output var logic serial_clock_pin, // serial clock, 400 ns period
	output var logic serial_in_pin // serial data
);
	logic got;
	initial begin
		chip_select_pin = 1'b0;
		serial_clock_pin = 1'b0;
		serial_in_pin = 1'b0;
		got = 1'b0;
	end
	task automatic tick(input int n);
		repeat (n) @(negedge clk_sys);
	endtask
	// got holds the answer to the previous rise, taken late in the low half
	task automatic bit1(input logic b);
		serial_clock_pin = 1'b0;
		serial_in_pin = b;
		tick(4);
		got = serial_out_pin;
		serial_clock_pin = 1'b1;
		tick(4);
	endtask
	task automatic start(input logic [7:0] ins);
		chip_select_pin = 1'b1;
		tick(2);
		bit1(1'b1);
		for (int i = 7; i >= 0; i--) begin
			bit1(ins[i]);
		end
	endtask
	task automatic data16(input logic [15:0] d, output logic [15:0] q);
		for (int i = 15; i >= 0; i--) begin
			bit1(d[i]);
			q[i] = got;
		end
	endtask
	task automatic stop();
		serial_clock_pin = 1'b0;
		tick(2);
		chip_select_pin = 1'b0;
		serial_in_pin = ~serial_in_pin;
		tick(6);
	endtask
	// select low for only two clocks, under the status minimum
	task automatic blip();
		serial_clock_pin = 1'b0;
		tick(2);
		chip_select_pin = 1'b0;
		tick(2);
		chip_select_pin = 1'b1;
		tick(8);
	endtask
	task automatic select();
		chip_select_pin = 1'b1;
		tick(8);
	endtask
endmodule // tse_host
`default_nettype wire

// >>> test/tse_eeprom_tb.sv
// self-checking bench for the serial word memory
// host model called by hierarchy; checker bound at the foot
`timescale 1ns/1ps
`default_nettype none
module tse_eeprom_tb
	import tse_pkg::*;
;
	localparam int PC = 200;
	logic clk_sys = 1'b0;
	logic rst_b = 1'b0;
	wire cs;
	wire sk;
	wire di;
	wire so;
	wire oe;
	wire so_bus;
	int bad_count = 0;
	int n_compared = 0;
	always #25 clk_sys = ~clk_sys;
	tse_eeprom #(.PROG_CYC(PC)) i_tse_eeprom (.clk_sys(clk_sys), .rst_b(rst_b), .chip_select_pin(cs),
		.serial_clock_pin(sk), .serial_in_pin(di), .serial_out_pin(so), .serial_out_oe(oe));
	// a released output shows the inverse of its last level, so reading a dead pin cannot pass
	assign so_bus = oe ? so : ~so;
	tse_host i_tse_host (.clk_sys(clk_sys), .serial_out_pin(so_bus), .chip_select_pin(cs),
		.serial_clock_pin(sk), .serial_in_pin(di));
	////////////////////////////////////////////////////////////
	task automatic conclude();
		if (bad_count == 0 && n_compared > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		n_compared++;
		if (seen !== exp) begin
			bad_count++;
			$display("MISMATCH %0t got %h want %h", $time, seen, exp);
		end
	endtask
	task automatic rd(input logic [ADDR_W-1:0] a, input logic [15:0] exp);
		logic [15:0] q;
		i_tse_host.start({OP_READ, a});
		i_tse_host.bit1(1'b0);
		check({15'h0, i_tse_host.got}, ZERO_WORD);
		i_tse_host.data16(ZERO_WORD, q);
		i_tse_host.stop();
		check(q, exp);
	endtask
	// on: a self-timed cycle is expected, so status must answer busy then ready
	task automatic prog(input logic [7:0] ins, input logic [15:0] d, input logic wd, input logic on);
		logic [15:0] q;
		int n;
		i_tse_host.start(ins);
		if (wd) begin
			i_tse_host.data16(d, q);
		end
		i_tse_host.stop();
		i_tse_host.select();
		check({15'h0, oe}, {15'h0, on});
		if (on) begin
			check({15'h0, so_bus}, ZERO_WORD);
			n = 0;
			while (so_bus !== 1'b1 && n < PC + 20) begin
				@(negedge clk_sys);
				n++;
			end
			check({15'h0, so_bus}, 16'h0001);
		end
		i_tse_host.stop();
	endtask
	////////////////////////////////////////////////////////////
	task automatic t_locked();
		rd(6'h00, ERASED_WORD);
		prog({OP_WRITE, 6'h05}, 16'h1234, 1'b1, 1'b0);
		rd(6'h05, ERASED_WORD);
	endtask
	task automatic t_word();
		prog({OP_EXT, EXT_ENABLE, 4'h5}, ZERO_WORD, 1'b0, 1'b0);
		prog({OP_WRITE, 6'h05}, 16'ha5c3, 1'b1, 1'b1);
		rd(6'h05, 16'ha5c3);
		rd(6'h06, ERASED_WORD);
		prog({OP_ERASE, 6'h05}, ZERO_WORD, 1'b0, 1'b1);
		rd(6'h05, ERASED_WORD);
	endtask
	task automatic t_whole();
		prog({OP_EXT, EXT_WRITE_ALL, 4'ha}, 16'h3c96, 1'b1, 1'b1);
		rd(6'h00, 16'h3c96);
		rd(6'h3f, 16'h3c96);
		prog({OP_EXT, EXT_ERASE_ALL, 4'h3}, ZERO_WORD, 1'b0, 1'b1);
		rd(6'h3f, ERASED_WORD);
	endtask
	task automatic t_late();
		logic [15:0] q;
		i_tse_host.start({OP_WRITE, 6'h07});
		i_tse_host.data16(16'h0f0f, q);
		i_tse_host.stop();
		repeat (PC + 20) @(negedge clk_sys);
		i_tse_host.select();
		check({15'h0, oe}, ZERO_WORD);
		i_tse_host.stop();
		prog({OP_EXT, EXT_DISABLE, 4'hc}, ZERO_WORD, 1'b0, 1'b0);
		prog({OP_WRITE, 6'h07}, ZERO_WORD, 1'b1, 1'b0);
		rd(6'h07, 16'h0f0f);
	endtask
	// a select low for too short a time must not ask for status
	task automatic t_short();
		logic [15:0] q;
		i_tse_host.start({OP_WRITE, 6'h0a});
		i_tse_host.data16(16'h5a5a, q);
		i_tse_host.blip();
		check({15'h0, oe}, ZERO_WORD);
		i_tse_host.stop();
		i_tse_host.select();
		check({15'h0, oe}, 16'h0001);
		check({15'h0, so_bus}, ZERO_WORD);
		repeat (PC + 20) @(negedge clk_sys);
		check({15'h0, so_bus}, 16'h0001);
		i_tse_host.stop();
		rd(6'h0a, 16'h5a5a);
	endtask
	// power loss drops the enable again
	task automatic t_power();
		prog({OP_EXT, EXT_ENABLE, 4'h0}, ZERO_WORD, 1'b0, 1'b0);
		rst_b = 1'b0;
		repeat (8) @(negedge clk_sys);
		rst_b = 1'b1;
		repeat (8) @(negedge clk_sys);
		prog({OP_ERASE, 6'h09}, ZERO_WORD, 1'b0, 1'b0);
	endtask
	////////////////////////////////////////////////////////////
	initial begin
		repeat (8) @(negedge clk_sys);
		rst_b = 1'b1;
		repeat (8) @(negedge clk_sys);
		t_locked();
		t_word();
		t_whole();
		t_short();
		t_late();
		t_power();
		conclude();
	end
	initial begin
		#1000000;
		bad_count++;
		conclude();
	end
endmodule // tse_eeprom_tb
bind tse_eeprom tse_eeprom_asserts i_tse_eeprom_asserts (.clk_sys(clk_sys), .rst_b(rst_b),
	.chip_select_pin(chip_select_pin), .serial_clock_pin(serial_clock_pin), .serial_in_pin(serial_in_pin),
	.serial_out_pin(serial_out_pin), .serial_out_oe(serial_out_oe));
`default_nettype wire
